// >>> frdp_defs.svh
// Register offsets, field positions and reset values for the PWM block
`ifndef FRDP_DEFS_SVH
`define FRDP_DEFS_SVH
`define FRDP_OFF_CTRL 12'h000
`define FRDP_OFF_PERIOD 12'h004
`define FRDP_OFF_COMPARE_A 12'h008
`define FRDP_OFF_ACTION 12'h00c
`define FRDP_OFF_EVT 12'h010
`define FRDP_OFF_STATUS 12'h014
`define FRDP_OFF_COUNT 12'h018
`define FRDP_CTRL_MODE_LSB 0
`define FRDP_CTRL_LOAD_LSB 2
`define FRDP_CTRL_RUN_BIT 4
`define FRDP_ACT_ZERO_LSB 0
`define FRDP_ACT_PRD_LSB 2
`define FRDP_ACT_CMP_UP_LSB 4
`define FRDP_ACT_CMP_DOWN_LSB 6
`define FRDP_EVT_EN_BIT 0
`define FRDP_EVT_DIV_LSB 1
`define FRDP_RST_PERIOD 16'hffff
`define FRDP_RST_COMPARE_A 16'h0000
`define FRDP_RST_ACTION 8'h00
`define FRDP_RST_CTRL 5'h00
`define FRDP_RST_EVT 3'h0
`endif

// >>> frdp_pkg.sv
// Types shared by the PWM block
package frdp_pkg;
  typedef enum logic [1:0] {
    FRDP_MODE_UP = 2'h0,
    FRDP_MODE_DOWN = 2'h1,
    FRDP_MODE_UPDOWN = 2'h2,
    FRDP_MODE_STOP = 2'h3
  } frdp_mode_t;
  // Output action per event: none, drive low, drive high, toggle
  typedef enum logic [1:0] {
    FRDP_ACT_NONE = 2'h0,
    FRDP_ACT_LOW = 2'h1,
    FRDP_ACT_HIGH = 2'h2,
    FRDP_ACT_TOGGLE = 2'h3
  } frdp_action_t;
  // Compare shadow load point: zero, period, zero or period, immediate
  typedef enum logic [1:0] {
    FRDP_LOAD_ZERO = 2'h0,
    FRDP_LOAD_PRD = 2'h1,
    FRDP_LOAD_ZERO_PRD = 2'h2,
    FRDP_LOAD_NOW = 2'h3
  } frdp_load_t;
  typedef struct packed {
    frdp_action_t compare_down_action;
    frdp_action_t compare_up_action;
    frdp_action_t period_action;
    frdp_action_t zero_match_action;
  } frdp_actions_t;
  typedef struct packed {
    logic zero;
    logic period;
    logic cmp_up;
    logic cmp_down;
  } frdp_events_t;
endpackage : frdp_pkg

// >>> frdp_action.sv
// Action qualifier: resolves simultaneous counter events into the next output level
`timescale 1ns/1ps
`default_nettype none
module frdp_action
  import frdp_pkg::*;
(
  input wire logic cur_level,
  input wire frdp_actions_t actions,
  input wire frdp_events_t events,
  output logic next_level
);
  function automatic logic apply(input logic lvl, input frdp_action_t a);
    unique case (a)
      FRDP_ACT_NONE: apply = lvl;
      FRDP_ACT_LOW: apply = 1'b0;
      FRDP_ACT_HIGH: apply = 1'b1;
      FRDP_ACT_TOGGLE: apply = ~lvl;
    endcase
  endfunction : apply

  // Compare events are applied last so they win over zero and period on a tie
  always_comb begin
    next_level = cur_level;
    if (events.zero) next_level = apply(next_level, actions.zero_match_action);
    if (events.period) next_level = apply(next_level, actions.period_action);
    if (events.cmp_up) next_level = apply(next_level, actions.compare_up_action);
    if (events.cmp_down) next_level = apply(next_level, actions.compare_down_action);
  end
endmodule : frdp_action
`default_nettype wire

// >>> frdp_pwm.sv
// Full range duty PWM: time base, shadowed compare A, action logic, zero event, APB slave
// Summary of operation
// - Counter runs up only, up then down, or down only.
// - Up-down: compare match counting up drives high, counting down drives low.
// - Up-down: compare 0 gives full high; compare at or above period gives none.
// - Event raised at counter zero; compare value loads from a shadow register.
// - Leaving zero: zero clears, down none, load zero-or-period; up match still sets.
// - Up-only: zero match drives high, compare match drives low.
// - Up-only: compare above period gives full high; compare 0 gives none.
// - Up-only leaving zero: zero sets, load zero-or-period; compare still clears.
//
// The implementer's own choices: the APB register port and the register offsets.
`include "frdp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module frdp_pwm
  import frdp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_output_a,
  output logic zero_event
);
  logic [4:0] ctrl_r;
  logic [15:0] period_r;
  logic [15:0] compare_a_shadow_r;
  logic [15:0] compare_a_value;
  frdp_actions_t output_a_action_control;
  logic [2:0] event_prescale_control;
  logic [15:0] count_r;
  logic dir_down_r;
  logic [1:0] evt_cnt_r;
  logic [15:0] count_nxt;
  logic dir_down_nxt;
  logic next_level;
  frdp_mode_t mode;
  frdp_load_t compare_load_point;
  frdp_events_t events;
  logic run;
  logic at_zero;
  logic at_period;
  logic load_now;
  logic setup_ok;
  logic acc;
  logic wr;
  logic rd;

  assign mode = frdp_mode_t'(ctrl_r[`FRDP_CTRL_MODE_LSB +: 2]);
  assign compare_load_point = frdp_load_t'(ctrl_r[`FRDP_CTRL_LOAD_LSB +: 2]);
  assign run = ctrl_r[`FRDP_CTRL_RUN_BIT] && (mode != FRDP_MODE_STOP);
  assign at_zero = run && (count_r == 16'h0000);
  assign at_period = run && (count_r == period_r);

  // Time base next value in each counting mode
  always_comb begin
    count_nxt = count_r;
    dir_down_nxt = dir_down_r;
    if (run) begin
      unique case (mode)
        FRDP_MODE_UP: begin
          dir_down_nxt = 1'b0;
          count_nxt = (count_r >= period_r) ? 16'h0000 : count_r + 16'h0001;
        end
        FRDP_MODE_DOWN: begin
          dir_down_nxt = 1'b1;
          count_nxt = (count_r == 16'h0000) ? period_r : count_r - 16'h0001;
        end
        FRDP_MODE_UPDOWN: begin
          if (period_r == 16'h0000) begin
            count_nxt = 16'h0000;
          end else if (!dir_down_r) begin
            if (count_r >= period_r) begin
              dir_down_nxt = 1'b1;
              count_nxt = period_r - 16'h0001;
            end else begin
              count_nxt = count_r + 16'h0001;
            end
          end else if (count_r == 16'h0000) begin
            dir_down_nxt = 1'b0;
            count_nxt = 16'h0001;
          end else begin
            count_nxt = count_r - 16'h0001;
          end
        end
        FRDP_MODE_STOP: begin
          count_nxt = count_r;
        end
      endcase
    end
  end

  // Counter and direction state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 16'h0000;
      dir_down_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      dir_down_r <= dir_down_nxt;
    end
  end

  // Compare events; a compare above the period never matches, which gives the
  // 0% up-down and 100% up-only corners without special hardware
  always_comb begin
    events.zero = at_zero;
    events.period = at_period;
    events.cmp_up = run && (count_r == compare_a_value) && !dir_down_r
                    && (mode != FRDP_MODE_DOWN);
    events.cmp_down = run && (count_r == compare_a_value)
                      && (dir_down_r || mode == FRDP_MODE_DOWN);
    // Up-down turns around at the top too; a match there counts as counting
    // down, so a compare equal to the period clears instead of setting
    if (mode == FRDP_MODE_UPDOWN && count_r == period_r && period_r != 16'h0000) begin
      events.cmp_up = 1'b0;
      events.cmp_down = run && (compare_a_value == period_r);
    end
    // Up-down turns around at zero; a match there counts as counting up
    if (mode == FRDP_MODE_UPDOWN && count_r == 16'h0000) begin
      events.cmp_up = run && (compare_a_value == 16'h0000);
      events.cmp_down = 1'b0;
    end
  end

  frdp_action u_action (
    .cur_level(pwm_output_a),
    .actions(output_a_action_control),
    .events(events),
    .next_level(next_level)
  );

  // Output pin follows the qualified action, straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pwm_output_a <= 1'b0;
    else pwm_output_a <= next_level;
  end

  // Shadow to active compare load; holding the load point keeps a half-written
  // value from reaching the comparator mid-cycle
  always_comb begin
    unique case (compare_load_point)
      FRDP_LOAD_ZERO: load_now = at_zero;
      FRDP_LOAD_PRD: load_now = at_period;
      FRDP_LOAD_ZERO_PRD: load_now = at_zero || at_period;
      FRDP_LOAD_NOW: load_now = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) compare_a_value <= `FRDP_RST_COMPARE_A;
    else if (load_now) compare_a_value <= compare_a_shadow_r;
  end

  // Zero event with divider: 0 or 1 means every zero match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_cnt_r <= 2'h0;
      zero_event <= 1'b0;
    end else begin
      zero_event <= 1'b0;
      if (at_zero && event_prescale_control[`FRDP_EVT_EN_BIT]) begin
        if (evt_cnt_r + 2'h1 >= event_prescale_control[`FRDP_EVT_DIV_LSB +: 2]) begin
          evt_cnt_r <= 2'h0;
          zero_event <= 1'b1;
        end else begin
          evt_cnt_r <= evt_cnt_r + 2'h1;
        end
      end
    end
  end

  // APB decode; zero wait states
  assign setup_ok = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = setup_ok && !pwrite;

  // Software registers; action and load point fields are rewritten by the
  // service routine at zero transitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `FRDP_RST_CTRL;
      period_r <= `FRDP_RST_PERIOD;
      compare_a_shadow_r <= `FRDP_RST_COMPARE_A;
      output_a_action_control <= frdp_actions_t'(`FRDP_RST_ACTION);
      event_prescale_control <= `FRDP_RST_EVT;
    end else if (wr) begin
      unique case (paddr)
        `FRDP_OFF_CTRL: ctrl_r <= pwdata[4:0];
        `FRDP_OFF_PERIOD: period_r <= pwdata[15:0];
        `FRDP_OFF_COMPARE_A: compare_a_shadow_r <= pwdata[15:0];
        `FRDP_OFF_ACTION: output_a_action_control <= frdp_actions_t'(pwdata[7:0]);
        `FRDP_OFF_EVT: event_prescale_control <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle so it is flop-driven in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ok;
      pslverr <= setup_ok && (paddr > `FRDP_OFF_COUNT || paddr[1:0] != 2'h0);
      if (rd) begin
        unique case (paddr)
          `FRDP_OFF_CTRL: prdata <= {27'h0, ctrl_r};
          `FRDP_OFF_PERIOD: prdata <= {16'h0, period_r};
          `FRDP_OFF_COMPARE_A: prdata <= {16'h0, compare_a_shadow_r};
          `FRDP_OFF_ACTION: prdata <= {24'h0, output_a_action_control};
          `FRDP_OFF_EVT: prdata <= {29'h0, event_prescale_control};
          `FRDP_OFF_STATUS: prdata <= {13'h0, pwm_output_a, dir_down_r, run,
                                       compare_a_value};
          `FRDP_OFF_COUNT: prdata <= {16'h0, count_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : frdp_pwm
`default_nettype wire

// >>> frdp_pwm_asserts.sv
// Port-level checker for the PWM block
`timescale 1ns/1ps
`default_nettype none
module frdp_pwm_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_output_a,
  input wire logic zero_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Register access answers in the cycle after setup, never held
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("answer outside access");
  // Error flag must track the map edges exactly
  a_err_beyond_map: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_no_err_mapped: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("mapped access refused");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Period is never zero in use, so the zero event is a lone pulse
  a_event_pulse: assert property (zero_event |=> !zero_event)
    else $error("zero event longer than one cycle");
  c_refused: cover property (pready && pslverr);
  c_event: cover property (zero_event);
  c_rise: cover property ($rose(pwm_output_a));
  c_fall: cover property ($fell(pwm_output_a));
endmodule : frdp_pwm_asserts
bind frdp_pwm frdp_pwm_asserts frdp_pwm_asserts_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output_a(pwm_output_a),
  .zero_event(zero_event));
`default_nettype wire

// >>> frdp_power_stage.sv
// Power stage model: counts the cycles its gate input is driven high
`timescale 1ns/1ps
`default_nettype none
module frdp_power_stage (
  input wire logic pclk,
  input wire logic gate,
  input wire logic clr,
  output logic [15:0] high_cycles
);
  // Sampled on the rising edge, like a gate driver latching its input
  always_ff @(posedge pclk) begin
    if (clr) begin
      high_cycles <= 16'h0;
    end else if (gate === 1'b1) begin
      high_cycles <= high_cycles + 16'h1;
    end
  end
endmodule : frdp_power_stage
`default_nettype wire

// >>> frdp_pwm_tb.sv
// Testbench: programs the PWM over APB and measures duty through the power stage
`timescale 1ns/1ps
`default_nettype none
module frdp_pwm_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q_s, evn;
  logic pready, pslverr, pwm_output_a, zero_event, e_s, clr = 1'b0;
  logic [15:0] high_cycles;
  int errors = 0, tests_run = 0;
  frdp_pwm frdp_pwm_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_output_a(pwm_output_a), .zero_event(zero_event));
  frdp_power_stage frdp_power_stage_i (.pclk(pclk), .gate(pwm_output_a), .clr(clr),
    .high_cycles(high_cycles));
  always #5 pclk = ~pclk;
  // Zero events seen in the same window as the duty count
  always @(posedge pclk) evn <= clr ? 32'h0 : evn + {31'h0, zero_event === 1'b1};
  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; the request stands until pready is seen at a rising edge,
  // and one idle edge follows so the next setup never lands in the same step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      tally_and_finish();
    end else begin
      q_s = prdata;
      e_s = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0);
    check(q_s, exp);
    check({31'h0, e_s}, {31'h0, err});
  endtask : rd
  // Program one setting, let the shadow settle, then count a whole number of periods
  task automatic run_case(input logic [31:0] ctl, act, cmp, input logic [15:0] hi);
    xfer(1'b1, 12'h00c, act);
    xfer(1'b1, 12'h008, cmp);
    xfer(1'b1, 12'h000, ctl);
    repeat (24) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (80) @(posedge pclk);
    @(negedge pclk);
    check({16'h0, high_cycles}, {16'h0, hi});
    check(evn, (ctl[1:0] == 2'h2) ? 32'ha : 32'h10);
    @(posedge pclk);
  endtask : run_case
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004, 32'hffff, 1'b0);
    rd(12'h008, 32'h0, 1'b0);
    rd(12'h01c, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    xfer(1'b1, 12'h004, 32'h4); // Period 4: up-down frame 8, up or down frame 5
    xfer(1'b1, 12'h010, 32'h1);
    run_case(32'h12, 32'h60, 32'h2, 16'h28);
    run_case(32'h12, 32'h62, 32'h0, 16'h50);
    run_case(32'h12, 32'h60, 32'h0, 16'h50);
    run_case(32'h1a, 32'h21, 32'h1, 16'h46);
    run_case(32'h12, 32'h60, 32'h4, 16'h0);
    run_case(32'h12, 32'h60, 32'h5, 16'h0);
    run_case(32'h10, 32'h12, 32'h2, 16'h20);
    run_case(32'h10, 32'h12, 32'h5, 16'h50);
    run_case(32'h10, 32'h11, 32'h0, 16'h0);
    run_case(32'h18, 32'h12, 32'h1, 16'h10);
    run_case(32'h1c, 32'h06, 32'h5, 16'h40);
    run_case(32'h14, 32'h03, 32'h5, 16'h28);
    run_case(32'h11, 32'h42, 32'h2, 16'h30);
    rd(12'h000, 32'h11, 1'b0);
    tally_and_finish();
  end
endmodule : frdp_pwm_tb
`default_nettype wire
